// ===== design/scvd_pkg.sv
// Purpose: Shared constants and types for the stack CPU core datapath.
// Assumes: One system clock; a machine cycle is two clock cycles.
// Notes: Opcode encoding and register port offsets are local to this core.
package scvd_pkg;

  // Widths and depths.
  localparam int FETCH_W = 12;
  localparam int NIB_W = 4;
  localparam int PTR_W = 8;
  localparam int RAM_DEPTH = 256;
  localparam int IRQ_LEVELS = 8;
  localparam int REG_DATA_W = 16;

  // Values after reset.
  localparam logic [11:0] FETCH_RESET = 12'h000;
  localparam logic [7:0] IR_RESET = 8'hc1;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic CTRL_RUN_RESET = 1'b1;

  // Flag register bit positions.
  localparam int FLAG_IE = 0;
  localparam int FLAG_JUMP = 2;
  localparam int FLAG_CARRY = 3;

  // Return stack step per element.
  localparam logic [7:0] RET_STEP = 8'h04;

  // Register port offsets.
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_FETCH = 4'h1;
  localparam logic [3:0] REG_FLAGS = 4'h2;
  localparam logic [3:0] REG_ESP = 4'h3;
  localparam logic [3:0] REG_RSP = 4'h4;
  localparam logic [3:0] REG_XPTR = 4'h5;
  localparam logic [3:0] REG_YPTR = 4'h6;
  localparam logic [3:0] REG_IRQ = 4'h7;

  // Interrupt vector addresses, lowest level first.
  localparam logic [8:0] VEC_ADDR [IRQ_LEVELS] = '{9'h040, 9'h080, 9'h0c0, 9'h100,
                                                  9'h140, 9'h180, 9'h1c0, 9'h1e0};

  // Single-byte opcodes.
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_ADD = 8'h01;
  localparam logic [7:0] OP_SUB = 8'h02;
  localparam logic [7:0] OP_AND = 8'h03;
  localparam logic [7:0] OP_OR = 8'h04;
  localparam logic [7:0] OP_XOR = 8'h05;
  localparam logic [7:0] OP_ROL = 8'h06;
  localparam logic [7:0] OP_ROR = 8'h07;
  localparam logic [7:0] OP_DROP = 8'h08;
  localparam logic [7:0] OP_DUP = 8'h09;
  localparam logic [7:0] OP_SET_JC = 8'h20;
  localparam logic [7:0] OP_TOG_J = 8'h21;
  localparam logic [7:0] OP_FLAG_ST = 8'h22;
  localparam logic [7:0] OP_MASK = 8'h23;
  localparam logic [7:0] OP_UNMASK = 8'h24;
  localparam logic [7:0] OP_SLEEP = 8'h25;
  localparam logic [7:0] OP_FLAG_LD = 8'h26;
  localparam logic [7:0] OP_RET = 8'h30;
  localparam logic [7:0] OP_SRV_RET = 8'h31;
  localparam logic [7:0] OP_TABLE = 8'h40;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_TABLE = 2'b01
  } scvd_state_t;

  // Internal I/O bus request bundle.
  typedef struct packed {
    logic [3:0] addr;
    logic [3:0] wdata;
    logic wr;
    logic rd;
  } scvd_io_t;

endpackage : scvd_pkg

// ===== design/scvd_core.sv
// Purpose: Datapath and sequencer of a 4-bit stack CPU core.
// Assumes: ROM answers within one clock of rom_addr; peripherals share sys_clk.
// Notes: RAM is internal; stack pointers hold no meaning until software loads them.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module scvd_core
  import scvd_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Program ROM.
  output logic [FETCH_W-1:0] rom_addr,
  input wire logic [7:0] rom_data,
  // Internal I/O bus.
  output scvd_io_t io_out,
  input wire logic [NIB_W-1:0] io_rdata,
  // Interrupt requests and handshake.
  input wire logic [IRQ_LEVELS-1:0] int_req,
  output logic [IRQ_LEVELS-1:0] int_ack,
  output logic [IRQ_LEVELS-1:0] int_done,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [REG_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_DATA_W-1:0] reg_rdata
);

  logic [NIB_W-1:0] ram [RAM_DEPTH];
  logic [FETCH_W-1:0] fetch_address_reg, fetch_address_next;
  logic [FETCH_W-1:0] rom_addr_reg, rom_addr_next;
  logic [7:0] ir_reg, ir_next;
  logic [7:0] expr_stack_ptr, sp_next, ret_stack_ptr, rp_next;
  logic [7:0] xptr_reg, xptr_next, yptr_reg, yptr_next;
  logic [NIB_W-1:0] stack_head, head_next, stack_second;
  logic [3:0] flag_register, flags_next;
  logic [IRQ_LEVELS-1:0] pending_reg, active_reg, act_set, act_clr;
  logic [IRQ_LEVELS-1:0] int_ack_reg, int_done_reg;
  scvd_state_t state_reg, state_next;
  logic phase_reg, run_reg, exec;
  scvd_io_t io_reg;
  logic [REG_DATA_W-1:0] reg_rdata_reg;
  logic [2:0] we;
  logic [7:0] wa [3];
  logic [NIB_W-1:0] wd [3];
  logic [FETCH_W-1:0] ret_top;
  logic [2:0] lvl_pend, lvl_act;
  logic irq_take;

  // Index of the highest set bit.
  function automatic logic [2:0] top_level(input logic [IRQ_LEVELS-1:0] v);
    logic [2:0] l;
    l = 3'd0;
    for (int i = 0; i < IRQ_LEVELS; i++) begin
      if (v[i]) begin
        l = 3'(i);
      end
    end
    return l;
  endfunction : top_level

  assign stack_second = ram[expr_stack_ptr];
  assign ret_top = {ram[8'(ret_stack_ptr + 8'd3)], ram[8'(ret_stack_ptr + 8'd2)],
                    ram[8'(ret_stack_ptr + 8'd1)]};
  assign lvl_pend = top_level(pending_reg);
  assign lvl_act = top_level(active_reg);
  assign exec = phase_reg & run_reg;
  // A level is taken only when enabled and above every level in service.
  assign irq_take = flag_register[FLAG_IE] & (|pending_reg)
                    & (~(|active_reg) | (lvl_pend > lvl_act));

  // Decode of the current instruction into next-state values.
  always_comb begin
    logic [4:0] alu5;
    logic [7:0] ptr, ptr_new;
    logic [NIB_W-1:0] val;
    logic normal;
    logic [FETCH_W-1:0] target, ret_addr;
    alu5 = 5'h00;
    ptr = ir_reg[1] ? yptr_reg : xptr_reg;
    ptr_new = ir_reg[0] ? 8'(ptr - 8'd1) : 8'(ptr + 8'd1);
    val = ir_reg[0] ? ram[ptr] : ram[ptr_new];
    normal = 1'b1;
    target = {ir_reg[3:0], rom_data};
    ret_addr = fetch_address_reg;
    fetch_address_next = 12'(fetch_address_reg + 12'd1);
    rom_addr_next = 12'(fetch_address_reg + 12'd1);
    ir_next = rom_data;
    head_next = stack_head;
    sp_next = expr_stack_ptr;
    rp_next = ret_stack_ptr;
    xptr_next = xptr_reg;
    yptr_next = yptr_reg;
    flags_next = flag_register;
    state_next = ST_RUN;
    act_set = '0;
    act_clr = '0;
    we = 3'b000;
    for (int k = 0; k < 3; k++) begin
      wa[k] = 8'h00;
      wd[k] = 4'h0;
    end
    if (state_reg == ST_TABLE) begin
      // ROM constant is on rom_data; push high then low nibble.
      we = 3'b011;
      wa[0] = 8'(expr_stack_ptr + 8'd1);
      wd[0] = stack_head;
      wa[1] = 8'(expr_stack_ptr + 8'd2);
      wd[1] = rom_data[7:4];
      head_next = rom_data[3:0];
      sp_next = 8'(expr_stack_ptr + 8'd2);
      normal = 1'b0;
      fetch_address_next = fetch_address_reg;
      rom_addr_next = fetch_address_reg;
      ir_next = OP_NOP;
    end else begin
      casez (ir_reg)
        8'b11??????, 8'b1000????: begin
          // Short vector call or long call: push return, jump to target.
          if (ir_reg[6]) begin
            target = {3'b000, ir_reg[5:0], 3'b000};
          end else begin
            ret_addr = 12'(fetch_address_reg + 12'd1);
          end
          rp_next = 8'(ret_stack_ptr + RET_STEP);
          we = 3'b111;
          for (int k = 0; k < 3; k++) begin
            wa[k] = 8'(ret_stack_ptr + RET_STEP + 8'(k + 1));
            wd[k] = ret_addr[4*k +: 4];
          end
          normal = 1'b0;
        end
        8'b1001????, 8'b1010????: begin
          // Branches; the conditional one skips its operand when jump is clear.
          if (!ir_reg[5] && !flag_register[FLAG_JUMP]) begin
            target = 12'(fetch_address_reg + 12'd1);
          end
          normal = 1'b0;
        end
        8'b0111????: begin
          // Literal push.
          we[0] = 1'b1;
          wa[0] = 8'(expr_stack_ptr + 8'd1);
          wd[0] = stack_head;
          sp_next = 8'(expr_stack_ptr + 8'd1);
          head_next = ir_reg[3:0];
        end
        8'b0101????: begin
          // Input: I/O read data are strobed in the second half, the clock that executes.
          we[0] = 1'b1;
          wa[0] = 8'(expr_stack_ptr + 8'd1);
          wd[0] = stack_head;
          sp_next = 8'(expr_stack_ptr + 8'd1);
          head_next = io_rdata;
        end
        8'b0110????, OP_DROP: begin
          head_next = stack_second;
          sp_next = 8'(expr_stack_ptr - 8'd1);
        end
        OP_DUP, OP_FLAG_LD: begin
          we[0] = 1'b1;
          wa[0] = 8'(expr_stack_ptr + 8'd1);
          wd[0] = stack_head;
          sp_next = 8'(expr_stack_ptr + 8'd1);
          head_next = ir_reg[5] ? flag_register : stack_head;
        end
        OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR: begin
          // Binary ALU: second op head, result to head, second popped.
          case (ir_reg[2:0])
            3'd1: alu5 = 5'({1'b0, stack_second} + {1'b0, stack_head});
            3'd2: alu5 = 5'({1'b0, stack_second} - {1'b0, stack_head});
            3'd3: alu5 = {flag_register[FLAG_CARRY], stack_second & stack_head};
            3'd4: alu5 = {flag_register[FLAG_CARRY], stack_second | stack_head};
            default: alu5 = {flag_register[FLAG_CARRY], stack_second ^ stack_head};
          endcase
          head_next = alu5[3:0];
          sp_next = 8'(expr_stack_ptr - 8'd1);
          flags_next[FLAG_CARRY] = alu5[4];
          flags_next[FLAG_JUMP] = (ir_reg[2:0] < 3'd3) ? alu5[4] : (alu5[3:0] == 4'h0);
        end
        OP_ROL, OP_ROR: begin
          // Carry acts as the fifth bit of the rotate.
          if (ir_reg[0]) begin
            {head_next, flags_next[FLAG_CARRY]} = {flag_register[FLAG_CARRY], stack_head};
          end else begin
            {flags_next[FLAG_CARRY], head_next} = {stack_head, flag_register[FLAG_CARRY]};
          end
          flags_next[FLAG_JUMP] = flags_next[FLAG_CARRY];
        end
        8'b00010???: begin
          // Pointer fetch or store through X or Y.
          if (ir_reg[1]) begin
            yptr_next = ptr_new;
          end else begin
            xptr_next = ptr_new;
          end
          we[1] = 1'b1;
          if (ir_reg[2]) begin
            wa[1] = ir_reg[0] ? ptr : ptr_new;
            wd[1] = stack_head;
            head_next = stack_second;
            sp_next = 8'(expr_stack_ptr - 8'd1);
          end else begin
            wa[1] = 8'(expr_stack_ptr + 8'd1);
            wd[1] = stack_head;
            head_next = val;
            sp_next = 8'(expr_stack_ptr + 8'd1);
          end
        end
        OP_SET_JC: begin
          flags_next[FLAG_JUMP] = 1'b1;
          flags_next[FLAG_CARRY] = 1'b1;
        end
        OP_TOG_J: flags_next[FLAG_JUMP] = ~flag_register[FLAG_JUMP];
        OP_FLAG_ST: begin
          flags_next = stack_head;
          head_next = stack_second;
          sp_next = 8'(expr_stack_ptr - 8'd1);
        end
        OP_MASK: flags_next[FLAG_IE] = 1'b0;
        OP_UNMASK, OP_SLEEP: flags_next[FLAG_IE] = 1'b1;
        OP_RET, OP_SRV_RET: begin
          target = ret_top;
          rp_next = 8'(ret_stack_ptr - RET_STEP);
          if (ir_reg[0]) begin
            act_clr[lvl_act] = 1'b1;
          end
          normal = 1'b0;
        end
        8'b001111??: begin
          // Two-byte pointer load from the operand byte.
          case (ir_reg[1:0])
            2'd0: sp_next = rom_data;
            2'd1: rp_next = rom_data;
            2'd2: xptr_next = rom_data;
            default: yptr_next = rom_data;
          endcase
          target = 12'(fetch_address_reg + 12'd1);
          normal = 1'b0;
        end
        OP_TABLE: begin
          // Steer the fetch path to the return stack top for one cycle.
          rom_addr_next = ret_top;
          fetch_address_next = fetch_address_reg;
          ir_next = ir_reg;
          state_next = ST_TABLE;
        end
        default: ;
      endcase
      if (!normal) begin
        fetch_address_next = target;
        rom_addr_next = target;
        ir_next = OP_NOP;
      end else if (irq_take && state_next == ST_RUN) begin
        // Replace the prefetched byte with a short vector call.
        ir_next = {2'b11, VEC_ADDR[lvl_pend][8:3]};
        fetch_address_next = fetch_address_reg;
        rom_addr_next = fetch_address_reg;
        act_set[lvl_pend] = 1'b1;
      end
    end
  end

  // Machine cycle phase: execute on the second clock.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= 1'b0;
    end else if (run_reg) begin
      phase_reg <= ~phase_reg;
    end
  end

  // Fetch, instruction and sequencer state.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_address_reg <= FETCH_RESET;
      rom_addr_reg <= FETCH_RESET;
      ir_reg <= IR_RESET;
      state_reg <= ST_RUN;
    end else if (exec) begin
      fetch_address_reg <= fetch_address_next;
      rom_addr_reg <= rom_addr_next;
      ir_reg <= ir_next;
      state_reg <= state_next;
    end
  end

  // Stack head, pointers and flags.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_head <= 4'h0;
      expr_stack_ptr <= PTR_RESET;
      ret_stack_ptr <= PTR_RESET;
      xptr_reg <= PTR_RESET;
      yptr_reg <= PTR_RESET;
      flag_register <= FLAGS_RESET;
    end else if (exec) begin
      stack_head <= head_next;
      expr_stack_ptr <= sp_next;
      ret_stack_ptr <= rp_next;
      xptr_reg <= xptr_next;
      yptr_reg <= yptr_next;
      flag_register <= flags_next;
    end
  end

  // Data RAM writes, up to three nibbles per machine cycle.
  always_ff @(posedge sys_clk) begin
    for (int k = 0; k < 3; k++) begin
      if (exec && we[k]) begin
        ram[wa[k]] <= wd[k];
      end
    end
  end

  // Pending requests are sticky; a new request beats a clear.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg <= '0;
      active_reg <= '0;
    end else begin
      pending_reg <= (pending_reg & ~(exec ? act_clr : '0)) | int_req;
      if (exec) begin
        active_reg <= (active_reg & ~act_clr) | act_set;
      end
    end
  end

  // Acknowledge and completion pulses.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_ack_reg <= '0;
      int_done_reg <= '0;
    end else begin
      int_ack_reg <= exec ? act_set : '0;
      int_done_reg <= exec ? act_clr : '0;
    end
  end

  // I/O strobes are registered at the end of the first half and asserted in the second half of the machine cycle.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_reg <= '0;
    end else begin
      io_reg.rd <= run_reg & ~phase_reg & (state_reg == ST_RUN)
                   & (ir_reg[7:4] == 4'h5);
      io_reg.wr <= run_reg & ~phase_reg & (state_reg == ST_RUN) & (ir_reg[7:4] == 4'h6);
      if (run_reg && !phase_reg) begin
        io_reg.addr <= ir_reg[3:0];
        io_reg.wdata <= stack_head;
      end
    end
  end

  // Register port writes: run control.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= CTRL_RUN_RESET;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      run_reg <= reg_wdata[0];
    end
  end

  // Register port reads, answered one cycle after the strobe.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_reg <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: reg_rdata_reg <= {15'h0000, run_reg};
        REG_FETCH: reg_rdata_reg <= {4'h0, fetch_address_reg};
        REG_FLAGS: reg_rdata_reg <= {12'h000, flag_register};
        REG_ESP: reg_rdata_reg <= {8'h00, expr_stack_ptr};
        REG_RSP: reg_rdata_reg <= {8'h00, ret_stack_ptr};
        REG_XPTR: reg_rdata_reg <= {8'h00, xptr_reg};
        REG_YPTR: reg_rdata_reg <= {8'h00, yptr_reg};
        REG_IRQ: reg_rdata_reg <= {active_reg, pending_reg};
        default: reg_rdata_reg <= '0;
      endcase
    end else begin
      reg_rdata_reg <= '0;
    end
  end

  assign rom_addr = rom_addr_reg;
  assign io_out = io_reg;
  assign int_ack = int_ack_reg;
  assign int_done = int_done_reg;
  assign reg_rdata = reg_rdata_reg;

endmodule : scvd_core

// ===== verification/scvd_core_props.sv
// Purpose: Port checks for the stack core.
// Assumes: One clock, reset active low.
// Notes: Bound to every core instance.
`timescale 1ns/1ps
module scvd_core_props
  import scvd_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Watched outputs.
  input wire logic [FETCH_W-1:0] rom_addr,
  input wire scvd_io_t io_out,
  input wire logic [IRQ_LEVELS-1:0] int_ack,
  input wire logic [IRQ_LEVELS-1:0] int_done
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  logic [3:0] age_reg;
  logic [8:0] vec_reg;

  // Counts clocks after reset so the boot call is checked once.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      age_reg <= 4'h0;
    end else if (age_reg != 4'hf) begin
      age_reg <= age_reg + 4'h1;
    end
  end

  // Keeps the vector of the level last taken.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_reg <= 9'h000;
    end else begin
      for (int i = 0; i < IRQ_LEVELS; i++) begin
        if (int_ack[i]) begin
          vec_reg <= VEC_ADDR[i];
        end
      end
    end
  end

  property p_rom_hold; $changed(rom_addr) |=> $stable(rom_addr); endproperty
  a_rom_hold: assert property (p_rom_hold)
    else $error("fetch address held one clock only");
  property p_boot; age_reg == 4'h1 |-> ##[1:8] (rom_addr == 12'h008); endproperty
  a_boot: assert property (p_boot)
    else $error("boot call target missed");
  property p_io_excl; !(io_out.wr && io_out.rd); endproperty
  a_io_excl: assert property (p_io_excl)
    else $error("io read and write together");
  property p_io_pulse; (io_out.wr || io_out.rd) |=> !(io_out.wr || io_out.rd); endproperty
  a_io_pulse: assert property (p_io_pulse)
    else $error("io strobes too close");
  property p_io_addr; io_out.wr |=> $stable(io_out.addr) && $stable(io_out.wdata); endproperty
  a_io_addr: assert property (p_io_addr)
    else $error("io address moved after write");
  property p_ack; int_ack != 8'h00 |-> $onehot(int_ack) ##1 (int_ack == 8'h00); endproperty
  a_ack: assert property (p_ack)
    else $error("ack not a one-hot pulse");
  property p_vec; int_ack != 8'h00 |-> ##[1:8] (rom_addr == {3'h0, vec_reg}); endproperty
  a_vec: assert property (p_vec)
    else $error("vector not fetched");
  property p_done; int_done != 8'h00 |-> $onehot(int_done) ##1 (int_done == 8'h00); endproperty
  a_done: assert property (p_done)
    else $error("done not a one-hot pulse");
endmodule : scvd_core_props

bind scvd_core scvd_core_props scvd_core_props_inst (.sys_clk(sys_clk), .rst_n(rst_n),
  .rom_addr(rom_addr), .io_out(io_out), .int_ack(int_ack), .int_done(int_done));

// ===== verification/scvd_partner.sv
// Purpose: Program ROM and peripheral model.
// Assumes: The bench loads the ROM just before it resets the core.
// Notes: Idle read data keep moving, so stale data never match.
`timescale 1ns/1ps
module scvd_partner
  import scvd_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Program ROM.
  input wire logic [FETCH_W-1:0] rom_addr,
  output logic [7:0] rom_data,
  // Internal I/O bus.
  input wire scvd_io_t io_out,
  output logic [NIB_W-1:0] io_rdata
);
  logic [7:0] rom_mem [4096];
  logic [3:0] io_mem [16];
  logic [3:0] noise_reg;
  int n_wr;

  // ROM answers at once; read data are valid only beside the strobe.
  assign rom_data = rom_mem[rom_addr];
  assign io_rdata = io_out.rd ? io_mem[io_out.addr] : noise_reg;

  // Peripheral registers take each write.
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        io_mem[i] <= 4'h0;
      end
      n_wr <= 0;
      noise_reg <= 4'ha;
    end else begin
      noise_reg <= noise_reg + 4'h5;
      if (io_out.wr) begin
        io_mem[io_out.addr] <= io_out.wdata;
        n_wr <= n_wr + 1;
      end
    end
  end
endmodule : scvd_partner

// ===== verification/scvd_core_bench.sv
// Purpose: Self-checking bench for the stack core.
// Assumes: Rows run one small program each after a reset.
// Notes: Row is {pre op, op, a, b, result, flags}.
`timescale 1ns/1ps
module scvd_core_bench
  import scvd_pkg::*;
;
  logic sys_clk, rst_n, reg_wr, reg_rd;
  logic [FETCH_W-1:0] rom_addr, hold_addr;
  logic [7:0] rom_data, int_req, int_ack, int_done, ack_seen, done_seen;
  scvd_io_t io_out;
  logic [3:0] io_rdata, reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd_val;
  logic [31:0] r;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] rows [16] = '{32'h00013580, 32'h0001f21c, 32'h00025320, 32'h000235ec,
    32'h2003ca88, 32'h00035a04, 32'h20045af8, 32'h00055504, 32'h0006092c, 32'h20060130,
    32'h0007094c, 32'h21000664, 32'h24000661, 32'h24230660, 32'h25000661, 32'h00223c3c};

  scvd_core scvd_core_inst (.sys_clk(sys_clk), .rst_n(rst_n), .rom_addr(rom_addr),
    .rom_data(rom_data), .io_out(io_out), .io_rdata(io_rdata), .int_req(int_req),
    .int_ack(int_ack), .int_done(int_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  scvd_partner scvd_partner_inst (.sys_clk(sys_clk), .rst_n(rst_n), .rom_addr(rom_addr),
    .rom_data(rom_data), .io_out(io_out), .io_rdata(io_rdata));

  // Clock of 40 ns.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Catches pulses and cuts a hang short.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    ack_seen <= !rst_n ? 8'h00 : (int_ack != 8'h00) ? int_ack : ack_seen;
    done_seen <= !rst_n ? 8'h00 : (int_done != 8'h00) ? int_done : done_seen;
    if (cycles == 5000) begin
      n_errors++;
      conclude();
    end
  end

  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task do_reset();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task load_rom(input logic [11:0] a, input logic [63:0] w);
    for (int i = 0; i < 8; i++) begin
      scvd_partner_inst.rom_mem[a + i] = w[63 - 8 * i -: 8];
    end
  endtask : load_rom

  task clear_rom();
    for (int i = 0; i < 4096; i++) begin
      scvd_partner_inst.rom_mem[i] = 8'h00;
    end
  endtask : clear_rom

  task reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  // Runs rows, then memory, interrupt and register cases.
  initial begin
    rst_n = 1'b0;
    int_req = 8'h00;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    foreach (rows[k]) begin
      r = rows[k];
      clear_rom();
      load_rom(12'h008, {16'h3c10, 4'h7, r[15:12], 4'h7, r[11:8], r[31:16], 16'h6026});
      load_rom(12'h010, 64'h6190_1770_62a0_1571);
      load_rom(12'h018, 64'h62a0_1900_0000_0000);
      do_reset();
      for (int i = 0; i < 300 && scvd_partner_inst.n_wr < 3; i++)
        @(posedge sys_clk);
      check("io writes", {4'h0, scvd_partner_inst.io_mem[0], scvd_partner_inst.io_mem[1],
        scvd_partner_inst.io_mem[2]}, {4'h0, r[7:0], 3'h0, r[2]});
      reg_read(REG_ESP, rd_val);
      check("expr ptr", rd_val, (r[23:16] inside {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
        OP_FLAG_ST}) ? 16'h0010 : 16'h0011);
      reg_read(REG_RSP, rd_val);
      check("ret ptr", rd_val, 16'h0004);
      $display("row %0d done", k);
    end
    // Input, pointer store and fetch, table constant, long call and return.
    clear_rom();
    load_rom(12'h000, 64'h5a00_0000_0000_0000);
    load_rom(12'h008, 64'h3c10_7963_533e_4014);
    load_rom(12'h010, 64'h1164_4080_30a0_1500);
    load_rom(12'h030, 64'h6566_3000_0000_0000);
    do_reset();
    for (int i = 0; i < 300 && scvd_partner_inst.n_wr < 4; i++)
      @(posedge sys_clk);
    check("io path", {scvd_partner_inst.io_mem[3], scvd_partner_inst.io_mem[4],
      scvd_partner_inst.io_mem[5], scvd_partner_inst.io_mem[6]}, 16'h99a5);
    reg_read(REG_XPTR, rd_val);
    check("x ptr", rd_val, 16'h0040);
    reg_read(REG_RSP, rd_val);
    check("call ret", rd_val, 16'h0004);
    $display("memory test done");
    clear_rom();
    load_rom(12'h008, 64'h3c10_3d20_0000_0000);
    load_rom(12'h020, 64'h2400_0000_0000_0000);
    load_rom(12'h038, 64'ha038_0000_0000_0000);
    load_rom(12'h0c0, 64'h726d_3100_0000_0000);
    do_reset();
    reg_read(REG_FLAGS, rd_val);
    check("flags", rd_val, 16'h0000);
    @(posedge sys_clk);
    int_req <= 8'h04;
    @(posedge sys_clk);
    int_req <= 8'h00;
    reg_read(REG_IRQ, rd_val);
    check("pending", rd_val, 16'h0004);
    check("early ack", {8'h00, ack_seen}, 16'h0000);
    for (int i = 0; i < 300 && ack_seen === 8'h00; i++)
      @(posedge sys_clk);
    check("ack", {8'h00, ack_seen}, 16'h0004);
    for (int i = 0; i < 300 && done_seen === 8'h00; i++)
      @(posedge sys_clk);
    check("done", {8'h00, done_seen}, 16'h0004);
    check("vector out", {12'h000, scvd_partner_inst.io_mem[13]}, 16'h0002);
    reg_read(REG_IRQ, rd_val);
    check("irq clear", rd_val, 16'h0000);
    reg_read(REG_RSP, rd_val);
    check("ret back", rd_val, 16'h0020);
    $display("irq test done");
    reg_read(4'h8, rd_val);
    check("unmapped", rd_val, 16'h0000);
    reg_write(REG_ESP, 16'h0055);
    reg_read(REG_ESP, rd_val);
    check("ptr kept", rd_val, 16'h0010);
    reg_write(REG_CTRL, 16'h0000);
    @(posedge sys_clk);
    #1 hold_addr = rom_addr;
    repeat (10) @(posedge sys_clk);
    #1 check("halted", {4'h0, rom_addr}, {4'h0, hold_addr});
    reg_write(REG_CTRL, 16'h0001);
    $display("register test done");
    conclude();
  end
endmodule : scvd_core_bench
